// ### rtl/bit_test_skip_and_call_exec.sv
// execution of bit-test skips and subroutine calls
// Overview of operation
// RULE1: test_bit_skip_if_clear cancels next instruction when the tested bit is 0.
// RULE2: test_bit_skip_if_set cancels next instruction when the tested bit is 1.
// RULE3: a taken skip discards the fetched word, runs a nop, two cycles.
// RULE4: file address 0..63 and bit 0..7 come from the instruction word.
// RULE5: both calls push program counter plus one onto the stack top.
// RULE6: immediate call loads adr low, pc_high_buffer[1:0] into bits 9:8.
// RULE7: call_via_acc loads table_high_pointer[1:0] high, accumulator low.
// RULE8: each call advances the stack pointer after storing the entry.
// RULE9: calls take two cycles; no status flag changes here.
`default_nettype none
module bit_test_skip_and_call_exec (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [exec_pkg::IW_W-1:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic [exec_pkg::DATA_W-1:0] file_data_i,
    input wire logic [exec_pkg::DATA_W-1:0] accumulator_i,
    input wire logic [exec_pkg::DATA_W-1:0] pc_high_buffer_i,
    input wire logic [exec_pkg::DATA_W-1:0] table_high_pointer_i,
    output logic [exec_pkg::FADDR_W-1:0] file_addr_o,
    output logic [exec_pkg::PC_W-1:0] pc_o,
    output logic flush_o,
    output logic busy_o,
    output logic [exec_pkg::SP_W-1:0] sp_o,
    output logic [exec_pkg::PC_W-1:0] stack_top_o,
    output logic status_we_o
);
    // decoded kind of the word in execute
    typedef enum logic [2:0] {
        KIND_NOP,
        KIND_SKIP_CLR,
        KIND_SKIP_SET,
        KIND_CALL_IMM,
        KIND_CALL_ACC
    } kind_t;

    // execute slot: normal, or discarding the fetched successor
    typedef enum logic {
        SLOT_RUN,
        SLOT_DISCARD
    } slot_t;

    // program counter, return address and call targets
    logic [exec_pkg::PC_W-1:0] pc_r;
    logic [exec_pkg::PC_W-1:0] pc_nxt;
    logic [exec_pkg::PC_W-1:0] ret_addr;
    logic [exec_pkg::PC_W-1:0] imm_target;
    logic [exec_pkg::PC_W-1:0] acc_target;
    logic [exec_pkg::PC_W-1:0] target;

    // fields cut from the instruction word, and the high call-target bits
    logic [exec_pkg::OPC_W-1:0] skip_opc;
    logic [exec_pkg::CALL_OPC_W-1:0] call_opc;
    logic [exec_pkg::BIT_W-1:0] bit_sel;
    logic [exec_pkg::DATA_W-1:0] imm_addr;
    logic [exec_pkg::HI_W-1:0] imm_hi;
    logic [exec_pkg::HI_W-1:0] acc_hi;

    // bit test terms
    logic [exec_pkg::DATA_W-1:0] bit_hit;
    logic bit_val;

    // slot state and decoded kind
    slot_t slot_r;
    slot_t slot_nxt;
    kind_t kind;

    // decode flags and decisions
    logic live;
    logic is_skip_clr;
    logic is_skip_set;
    logic is_call_imm;
    logic is_call_acc;
    logic skip_take;
    logic call_go;

    // operand fields straight from the instruction word
    assign file_addr_o =
        instr_i[exec_pkg::FADDR_LSB +: exec_pkg::FADDR_W]; // RULE4
    assign bit_sel = instr_i[exec_pkg::BIT_LSB +: exec_pkg::BIT_W]; // RULE4
    assign skip_opc = instr_i[exec_pkg::OPC_LSB +: exec_pkg::OPC_W];
    assign call_opc =
        instr_i[exec_pkg::CALL_OPC_LSB +: exec_pkg::CALL_OPC_W];

    // low target byte of the immediate call
    assign imm_addr = instr_i[exec_pkg::IMM_LSB +: exec_pkg::DATA_W]; // RULE6

    // high program counter bits for the two call kinds
    assign imm_hi = pc_high_buffer_i[exec_pkg::HI_W-1:0]; // RULE6
    assign acc_hi = table_high_pointer_i[exec_pkg::HI_W-1:0]; // RULE7

    // full call targets, high bits above the low byte
    assign imm_target = {imm_hi, imm_addr}; // RULE6
    assign acc_target = {acc_hi, accumulator_i}; // RULE7

    // return address, also the plain step
    assign ret_addr = pc_r + exec_pkg::PC_ONE; // RULE5

    // one term per bit, set only at the selected bit
    genvar g;
    generate
        for (g = 0; g < exec_pkg::DATA_W; g++) begin : g_bit
            localparam int unsigned BIT_IDX = g;
            assign bit_hit[g] = file_data_i[g]
                && bit_sel == BIT_IDX[exec_pkg::BIT_W-1:0]; // RULE4
        end
    endgenerate

    // tested bit is any set term
    assign bit_val = |bit_hit;

    // a word in the discard slot is executed as a nop
    assign live = instr_valid_i && slot_r == SLOT_RUN; // RULE3

    // opcode matches for the four instructions
    assign is_skip_clr = skip_opc == exec_pkg::OPC_SKIP_CLR;
    assign is_skip_set = skip_opc == exec_pkg::OPC_SKIP_SET;
    assign is_call_imm = call_opc == exec_pkg::OPC_CALL_IMM;
    assign is_call_acc = instr_i == exec_pkg::IW_CALL_ACC;

    // sort the word in execute into one kind
    always_comb begin
        kind = KIND_NOP;
        if (!live) begin
            kind = KIND_NOP; // RULE3
        end else if (is_skip_clr) begin
            kind = KIND_SKIP_CLR;
        end else if (is_skip_set) begin
            kind = KIND_SKIP_SET;
        end else if (is_call_imm) begin
            kind = KIND_CALL_IMM;
        end else if (is_call_acc) begin
            kind = KIND_CALL_ACC;
        end
    end

    // skip decision, call request and call target per kind
    always_comb begin
        skip_take = 1'h0;
        call_go = 1'h0;
        target = pc_r;
        unique case (kind)
            KIND_NOP: begin
                skip_take = 1'h0;
            end
            KIND_SKIP_CLR: begin
                skip_take = !bit_val; // RULE1
            end
            KIND_SKIP_SET: begin
                skip_take = bit_val; // RULE2
            end
            KIND_CALL_IMM: begin
                call_go = 1'h1; // RULE5
                target = imm_target; // RULE6
            end
            KIND_CALL_ACC: begin
                call_go = 1'h1; // RULE5
                target = acc_target; // RULE7
            end
        endcase
    end

    // next program counter: call target, step, or hold while idle
    always_comb begin
        pc_nxt = pc_r;
        if (call_go) begin
            pc_nxt = target; // RULE6 RULE7
        end else if (instr_valid_i) begin
            pc_nxt = ret_addr; // RULE3
        end
    end

    // program counter register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pc_r <= exec_pkg::PC_RST;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    // a taken skip or a call discards the fetched successor
    always_comb begin
        slot_nxt = SLOT_RUN;
        unique case (slot_r)
            SLOT_RUN: begin
                if (skip_take || call_go) begin
                    slot_nxt = SLOT_DISCARD; // RULE3 RULE9
                end
            end
            SLOT_DISCARD: begin
                slot_nxt = SLOT_RUN; // RULE3
            end
        endcase
    end

    // slot register, normal after reset
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            slot_r <= SLOT_RUN;
        end else begin
            slot_r <= slot_nxt;
        end
    end

    // return stack: push of the return address, pointer advance
    return_stack u_stack (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .push_i(call_go), // RULE5
        .push_addr_i(ret_addr), // RULE5
        .sp_o(sp_o),
        .top_o(stack_top_o)
    );

    // program counter and slot state to the core
    assign pc_o = pc_r;
    assign flush_o = slot_r == SLOT_DISCARD; // RULE3
    assign busy_o = slot_r == SLOT_DISCARD; // RULE9

    // no instruction here writes a status flag
    assign status_we_o = 1'h0; // RULE9
endmodule
`default_nettype wire

// ### rtl/exec_pkg.sv
// constants for the bit-test, skip and call execution block
`default_nettype none
package exec_pkg;
    localparam int PC_W = 10;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 6;
    localparam int BIT_W = 3;
    localparam int IW_W = 14;
    localparam int STK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int HI_W = 2;
    // instruction word fields
    localparam int OPC_LSB = 9;
    localparam int OPC_W = 5;
    localparam int BIT_LSB = 6;
    localparam int FADDR_LSB = 0;
    localparam int IMM_LSB = 0;
    localparam int CALL_OPC_LSB = 8;
    localparam int CALL_OPC_W = 6;
    // opcode encodings, chosen by the core's decoder, then reset and step values
    localparam logic [4:0] OPC_SKIP_CLR = 5'h0A;
    localparam logic [4:0] OPC_SKIP_SET = 5'h0B;
    localparam logic [5:0] OPC_CALL_IMM = 6'h18;
    localparam logic [IW_W-1:0] IW_CALL_ACC = 14'h0003;
    localparam logic [PC_W-1:0] PC_RST = 10'h000;
    localparam logic [PC_W-1:0] PC_ONE = 10'h001;
    localparam logic [SP_W-1:0] SP_RST = 3'h0;
    localparam logic [SP_W-1:0] SP_ONE = 3'h1;
    typedef enum logic [1:0] {
        OP_NONE, OP_SKIP_CLR, OP_SKIP_SET, OP_CALL_IMM
    } op_t;
endpackage
`default_nettype wire

// ### rtl/return_stack.sv
// hardware return-address stack with push pointer
`default_nettype none
module return_stack (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic push_i,
    input wire logic [exec_pkg::PC_W-1:0] push_addr_i,
    output logic [exec_pkg::SP_W-1:0] sp_o,
    output logic [exec_pkg::PC_W-1:0] top_o
);
    logic [exec_pkg::PC_W-1:0] mem_r [exec_pkg::STK_DEPTH];
    logic [exec_pkg::SP_W-1:0] sp_r;

    // entry at the pointer takes the address, then pointer moves on
    genvar g;
    generate
        for (g = 0; g < exec_pkg::STK_DEPTH; g++) begin : g_ent
            localparam int unsigned ENT_IDX = g;
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    mem_r[g] <= exec_pkg::PC_RST;
                end else if (push_i && sp_r == ENT_IDX[exec_pkg::SP_W-1:0]) begin
                    mem_r[g] <= push_addr_i; // RULE5
                end
            end
        end
    endgenerate

    // pointer advance after storing
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sp_r <= exec_pkg::SP_RST;
        end else if (push_i) begin
            sp_r <= sp_r + exec_pkg::SP_ONE; // RULE8
        end
    end

    assign sp_o = sp_r;
    assign top_o = mem_r[sp_r - exec_pkg::SP_ONE];
endmodule
`default_nettype wire

// ### testbench/exec_assertions.sv
// checker for the skip and call execution block
`default_nettype none
module exec_assertions (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic instr_valid_i,
    input wire logic flush_o,
    input wire logic busy_o,
    input wire logic status_we_o,
    input wire logic [13:0] instr_i,
    input wire logic [7:0] file_data_i,
    input wire logic [7:0] accumulator_i,
    input wire logic [7:0] pc_high_buffer_i,
    input wire logic [7:0] table_high_pointer_i,
    input wire logic [5:0] file_addr_o,
    input wire logic [9:0] pc_o,
    input wire logic [9:0] stack_top_o,
    input wire logic [2:0] sp_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // taken word, opcode and tested bit
    wire logic t = instr_valid_i && !flush_o;
    wire logic [4:0] op = instr_i[13:9];
    wire logic b = file_data_i[instr_i[8:6]];
    wire logic clr = op == exec_pkg::OPC_SKIP_CLR;
    wire logic set = op == exec_pkg::OPC_SKIP_SET;
    wire logic ca = instr_i == exec_pkg::IW_CALL_ACC;
    wire logic ci = instr_i[13:8] == exec_pkg::OPC_CALL_IMM;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_skip; t && (clr && !b || set && b); endsequence
    sequence s_call; t && (ci || ca); endsequence
    sequence s_slot; flush_o ##1 !flush_o; endsequence
    property p_skip; s_skip |=> s_slot; endproperty
    property p_stay; t && (clr && b || set && !b) |=> !flush_o; endproperty
    property p_pc; s_skip |=> pc_o == $past(pc_o) + 10'h001; endproperty
    property p_addr; file_addr_o == instr_i[5:0]; endproperty
    property p_push; s_call |=> stack_top_o == $past(pc_o) + 10'h001
        && sp_o == $past(sp_o) + 3'h1; endproperty
    property p_imm; t && ci |=> pc_o == {2'($past(pc_high_buffer_i)),
        8'($past(instr_i))}; endproperty
    property p_acc; t && ca |=> pc_o == {2'($past(table_high_pointer_i)),
        $past(accumulator_i)}; endproperty
    property p_two; s_call |=> s_slot and ##1 $stable(sp_o); endproperty
    property p_busy; s_call |=> busy_o ##1 !busy_o; endproperty
    property p_flag; !status_we_o; endproperty
    a_skip: assert property (p_skip) else $error("skip");
    a_stay: assert property (p_stay) else $error("stay");
    a_pc: assert property (p_pc) else $error("skip pc");
    a_addr: assert property (p_addr) else $error("addr");
    a_push: assert property (p_push) else $error("push");
    a_imm: assert property (p_imm) else $error("imm");
    a_acc: assert property (p_acc) else $error("acc");
    a_two: assert property (p_two) else $error("two");
    a_busy: assert property (p_busy) else $error("busy");
    a_flag: assert property (p_flag) else $error("flag write");
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the skip and call execution block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, sys_rst_i = 1, instr_valid_i = 0;
    logic [13:0] instr_i = 0;
    logic [7:0] file_data_i = 0, accumulator_i = 0;
    logic [7:0] pc_high_buffer_i = 0, table_high_pointer_i = 0;
    logic [5:0] file_addr_o;
    logic [9:0] pc_o, stack_top_o, ep = 0;
    logic [2:0] sp_o, es = 0;
    logic flush_o, busy_o, status_we_o;
    int err_count = 0, cmp_count = 0;
    bit_test_skip_and_call_exec bit_test_skip_and_call_exec_i (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .instr_i(instr_i),
        .instr_valid_i(instr_valid_i),
        .file_data_i(file_data_i),
        .accumulator_i(accumulator_i),
        .pc_high_buffer_i(pc_high_buffer_i),
        .table_high_pointer_i(table_high_pointer_i),
        .file_addr_o(file_addr_o),
        .pc_o(pc_o),
        .flush_o(flush_o),
        .busy_o(busy_o),
        .sp_o(sp_o),
        .stack_top_o(stack_top_o),
        .status_we_o(status_we_o)
    );
    always #50 clk_i = ~clk_i;
    task automatic end_of_test();
        if (err_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(string n, logic [9:0] e, logic [9:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    // one execute cycle, driven at the falling edge
    task automatic step(logic [13:0] w, logic [7:0] d = 0, logic v = 1);
        instr_i = w;
        file_data_i = d;
        instr_valid_i = v;
        ep = ep + 10'(v);
        #1 chk("addr", 10'(w[5:0]), 10'(file_addr_o));
        @(negedge clk_i);
    endtask
    // both tests, every bit, other bits opposite
    task automatic t_skip();
        for (int i = 0; i < 32; i++) begin
            logic [7:0] m;
            logic k;
            m = 8'h01 << i[2:0];
            k = i[4] ~^ i[3];
            step({i[3] ? exec_pkg::OPC_SKIP_SET : exec_pkg::OPC_SKIP_CLR,
                i[2:0], 6'(63 - i)}, i[4] ? m : ~m);
            chk("flush", 10'(k), 10'(flush_o));
            chk("busy", 10'(k), 10'(busy_o));
            step(k ? {exec_pkg::OPC_SKIP_CLR, 9'h000} : 14'h0000);
            chk("pc", ep, pc_o);
            chk("slot", 10'h000, 10'(flush_o));
        end
    endtask
    // calls of both kinds, stack wraps after eight
    task automatic t_call();
        step(14'h0000, 8'h00, 1'b0);
        chk("hold", ep, pc_o);
        for (int i = 0; i < 8; i++) begin
            logic [9:0] tg;
            pc_high_buffer_i = 8'hFC | 8'(i >> 1);
            table_high_pointer_i = 8'h04 | 8'(i >> 1);
            accumulator_i = 8'(165 ^ i);
            tg = {2'(i >> 1), i[0] ? accumulator_i : 8'h3C};
            es++;
            step(i[0] ? exec_pkg::IW_CALL_ACC
                : {exec_pkg::OPC_CALL_IMM, 8'h3C});
            chk("top", ep, stack_top_o);
            chk("pc", tg, pc_o);
            chk("sp", 10'(es), 10'(sp_o));
            chk("busy", 10'h001, 10'(busy_o));
            chk("flags", 10'h000, 10'(status_we_o));
            ep = tg;
            step(exec_pkg::IW_CALL_ACC);
            chk("slot", ep, pc_o);
            chk("slot sp", 10'(es), 10'(sp_o));
        end
    endtask
    // reset in mid-run, then a call on the cleared stack
    task automatic t_reset();
        step(exec_pkg::IW_CALL_ACC);
        sys_rst_i = 1;
        @(negedge clk_i);
        sys_rst_i = 0;
        chk("rst pc", 10'h000, pc_o);
        chk("rst sp", 10'h000, 10'(sp_o));
        chk("rst slot", 10'h000, 10'(flush_o));
        ep = 10'h000;
        es = 3'h1;
        step(exec_pkg::IW_CALL_ACC);
        chk("rst top", ep, stack_top_o);
        chk("rst push", 10'(es), 10'(sp_o));
        chk("rst pc acc", 10'h3A2, pc_o);
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        sys_rst_i = 0;
        t_skip();
        t_call();
        t_reset();
        end_of_test();
    end
    // watchdog against a hang
    initial begin
        #100us;
        err_count++;
        end_of_test();
    end
endmodule
bind bit_test_skip_and_call_exec exec_assertions exec_assertions_i (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .instr_valid_i(instr_valid_i),
    .flush_o(flush_o),
    .busy_o(busy_o),
    .status_we_o(status_we_o),
    .instr_i(instr_i),
    .file_data_i(file_data_i),
    .accumulator_i(accumulator_i),
    .pc_high_buffer_i(pc_high_buffer_i),
    .table_high_pointer_i(table_high_pointer_i),
    .file_addr_o(file_addr_o),
    .pc_o(pc_o),
    .stack_top_o(stack_top_o),
    .sp_o(sp_o)
);
`default_nettype wire
